// ===== rtl/mcu_decode_pkg.sv
/*
 Constants, encodings and carrier types shared by the 14-bit instruction decoder.
 Assumes a single instruction clock domain and a synchronous core reset.
*/
package mcu_decode_pkg;

   // Instruction group in bits 13:12.
   localparam logic [1:0] GRP_BYTE   = 2'h0;
   localparam logic [1:0] GRP_BIT    = 2'h1;
   localparam logic [1:0] GRP_BRANCH = 2'h2;
   localparam logic [1:0] GRP_LIT    = 2'h3;

   // Byte-oriented op field in bits 11:8.
   localparam logic [3:0] OP_STORE   = 4'h0;
   localparam logic [3:0] OP_ZERO    = 4'h1;
   localparam logic [3:0] OP_SUB     = 4'h2;
   localparam logic [3:0] OP_DEC     = 4'h3;
   localparam logic [3:0] OP_OR      = 4'h4;
   localparam logic [3:0] OP_AND     = 4'h5;
   localparam logic [3:0] OP_XOR     = 4'h6;
   localparam logic [3:0] OP_ADD     = 4'h7;
   localparam logic [3:0] OP_MOV     = 4'h8;
   localparam logic [3:0] OP_INV     = 4'h9;
   localparam logic [3:0] OP_INC     = 4'ha;
   localparam logic [3:0] OP_DECSKIP = 4'hb;
   localparam logic [3:0] OP_RR      = 4'hc;
   localparam logic [3:0] OP_RL      = 4'hd;
   localparam logic [3:0] OP_SWAP    = 4'he;
   localparam logic [3:0] OP_INCSKIP = 4'hf;

   // Bit-oriented sub-code in bits 11:10.
   localparam logic [1:0] BIT_ZERO      = 2'h0;
   localparam logic [1:0] BIT_ONE       = 2'h1;
   localparam logic [1:0] BIT_TEST_ZERO = 2'h2;
   localparam logic [1:0] BIT_TEST_ONE  = 2'h3;

   // Control words: low byte when bits 13:8 are all zero.
   localparam logic [7:0] CTL_RETURN = 8'h08;
   localparam logic [7:0] CTL_RETI   = 8'h09;
   localparam logic [7:0] CTL_KICK   = 8'h63 + 8'h01;
   localparam logic [7:0] CTL_SLEEP  = 8'h63;
   localparam logic [7:0] NOP_MASK   = 8'h9f;

   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [7:0]  ACC_RST  = 8'h00;

   localparam logic [6:0] PORT_ADDR_DFLT       = 7'h05;
   localparam logic [6:0] TIMER_ZERO_ADDR_DFLT = 7'h01;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
   typedef enum logic [2:0] {PC_STEP, PC_SKIP, PC_CALL, PC_JUMP, PC_RETURN, PC_RETI} pc_op_e;

   typedef struct packed {
      logic timeout_flag_n;
      logic sleep_flag_n;
      logic z;
      logic dc;
      logic c;
   } status_s;

   localparam status_s STATUS_RST = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};

endpackage : mcu_decode_pkg

// ===== rtl/mcu_14bit_instruction_decoder.sv
/*
 Decode and execute control for 14-bit instruction words: four clock phases per
 instruction cycle, file register read-modify-write, accumulator and status flags.
 Assumes the fetch path presents the next word on INSTR_IN during phase Q1 and the
 file space returns read data combinationally while FILE_RD_OUT is high.
*/
`timescale 1ns/100ps

// Operation
// (RULE_01) Byte ops 0101/0100/0110/1001/1010/0011/1000 AND/OR/XOR/invert/inc/dec/move; Z only.
// (RULE_02) Byte op 0111 adds, 0010 subtracts accumulator from register; carry, digit carry, zero.
// (RULE_03) Destination bit 7 zero writes accumulator, one writes the file register.
// (RULE_04) 1101/1100 rotate through carry, updating carry; 1110 swaps nibbles, flags kept.
// (RULE_05) 1011/1111 decrement/increment, skip next on zero result; no flag change.
// (RULE_06) 0001 clears register or accumulator by bit 7, sets zero; 0000 d=1 stores accumulator.
// (RULE_07) Bit ops take index bits 9:7, seven-bit address; 00 clears, 01 sets bit.
// (RULE_08) Bit test 10 skips on zero, 11 on one; skipped word becomes a no-op cycle.
// (RULE_09) Literal 111x adds literal to accumulator, 110x literal minus accumulator; C, DC, Z.
// (RULE_10) Literal 1001 AND, 1000 OR, 1010 XOR into accumulator; zero flag only.
// (RULE_11) Literal 00xx loads accumulator; 01xx loads and returns in two cycles; flags kept.
// (RULE_12) Group 10 calls when bit 11 zero, jumps when one; 11-bit target, two cycles.
// (RULE_13) Words 0x0008 return and 0x0009 return from interrupt; two cycles, flags kept.
// (RULE_14) Low byte 0x64 kicks watchdog, 0x63 enters standby; both set timeout/sleep flags; standby here clears sleep_flag_n.
// (RULE_15) Word 00 0000 0xx0 0000 is a one-cycle no-op with no flag change.
// (RULE_16) Reads of the port register come from synchronised pin levels, not the latch.
// (RULE_17) A write to the timer count register clears the prescaler when assigned there.
// (RULE_18) Program counter change or true test costs two cycles, second as no-op.
// (RULE_19) One instruction cycle spans four clock periods.
// (RULE_20) Every instruction naming a file register reads it before writing the result.
// (RULE_21) File address is seven bits, registers 0x00 through 0x7F.
module mcu_14bit_instruction_decoder
   import mcu_decode_pkg::*;
#(
   parameter logic [6:0] PORT_ADDR       = PORT_ADDR_DFLT,
   parameter logic [6:0] TIMER_ZERO_ADDR = TIMER_ZERO_ADDR_DFLT
) (
   input  wire logic        MCLK_IN,
   input  wire logic        RST_IN,
   input  wire logic [13:0] INSTR_IN,
   input  wire logic [7:0]  FILE_RDATA_IN,
   input  wire logic [7:0]  PORT_PINS_IN,
   input  wire logic        PRESCALER_ON_TIMER_IN,
   output logic             TAKEN_OUT,
   output logic             NOP_CYCLE_OUT,
   output logic [6:0]       FILE_ADDR_OUT,
   output logic             FILE_RD_OUT,
   output logic             FILE_WE_OUT,
   output logic [7:0]       FILE_WDATA_OUT,
   output logic [7:0]       ACC_OUT,
   output status_s          STATUS_OUT,
   output pc_op_e           PC_OP_OUT,
   output logic [10:0]      TARGET_OUT,
   output logic             PRESCALER_CLR_OUT,
   output logic             WDT_CLR_OUT,
   output logic             STANDBY_OUT
);

   phase_e      phase_r, phase_nxt;
   logic [13:0] ir_r, ir_nxt;
   logic        flush_r, flush_nxt;
   logic        nop_r, nop_nxt;
   logic        taken_r, taken_nxt;
   logic [6:0]  addr_r, addr_nxt;
   logic        rd_r, rd_nxt;
   logic        we_r, we_nxt;
   logic [7:0]  wdata_r, wdata_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic [7:0]  acc_r, acc_nxt;
   status_s     stat_r, stat_nxt;
   pc_op_e      pcop_r, pcop_nxt;
   logic [10:0] target_r, target_nxt;
   logic        presc_r, presc_nxt;
   logic        kick_r, kick_nxt;
   logic        standby_r, standby_nxt;
   logic [7:0]  pin_s1_r;
   logic [7:0]  pin_s2_r;

   function automatic logic [9:0] add_sub(input logic [7:0] a, input logic [7:0] b,
                                          input logic sub);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] h;
      bb = sub ? ~b : b;
      s  = {1'h0, a} + {1'h0, bb} + {8'h00, sub};
      h  = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + {4'h0, sub};
      return {s[8], h[4], s[7:0]};
   endfunction : add_sub

   // True when the word names a file register and so must read it first.
   function automatic logic names_file(input logic [13:0] i);
      if (i[13:12] == GRP_BIT) begin
         return 1'h1;
      end
      if (i[13:12] != GRP_BYTE) begin
         return 1'h0;
      end
      return (i[11:8] == OP_STORE || i[11:8] == OP_ZERO) ? i[7] : 1'h1;
   endfunction : names_file

   always_comb begin
      logic [7:0] f;
      logic [7:0] w;
      logic [7:0] k;
      logic [7:0] res;
      logic [2:0] b;
      logic       wr_f;
      logic       wr_a;
      logic       upd_z;
      logic       skip;
      logic       kick;
      logic       stby;
      pc_op_e     pcop;
      status_s    st;
      f     = rdata_r;
      w     = acc_r;
      k     = ir_r[7:0];
      b     = ir_r[9:7];
      res   = 8'h00;
      wr_f  = 1'h0;
      wr_a  = 1'h0;
      upd_z = 1'h0;
      skip  = 1'h0;
      kick  = 1'h0;
      stby  = 1'h0;
      pcop  = PC_STEP;
      st    = stat_r;
      unique case (ir_r[13:12])
         GRP_BYTE: begin
            wr_f = ir_r[7]; // RULE_03
            wr_a = ~ir_r[7]; // RULE_03
            unique case (ir_r[11:8])
               OP_STORE: begin
                  wr_a = 1'h0;
                  res  = w; // RULE_06
                  if (!ir_r[7]) begin
                     if (k == CTL_RETURN) begin
                        pcop = PC_RETURN; // RULE_13
                     end else if (k == CTL_RETI) begin
                        pcop = PC_RETI; // RULE_13
                     end else if (k == CTL_KICK) begin
                        kick = 1'h1; // RULE_14
                        st.timeout_flag_n = 1'h1;
                        st.sleep_flag_n   = 1'h1;
                     end else if (k == CTL_SLEEP) begin
                        stby = 1'h1; // RULE_14
                        st.timeout_flag_n = 1'h1;
                        st.sleep_flag_n   = 1'h0;
                     end else if ((k & NOP_MASK) == 8'h00) begin
                        pcop = PC_STEP; // RULE_15
                     end
                     // Any other unassigned control word does nothing as well.
                  end
               end
               OP_ZERO: begin
                  res   = 8'h00; // RULE_06
                  upd_z = 1'h1;
               end
               OP_SUB, OP_ADD: begin
                  {st.c, st.dc, res} = add_sub(f, w, ir_r[11:8] == OP_SUB); // RULE_02
                  upd_z = 1'h1;
               end
               OP_AND: begin res = f & w; upd_z = 1'h1; end // RULE_01
               OP_OR: begin res = f | w; upd_z = 1'h1; end // RULE_01
               OP_XOR: begin res = f ^ w; upd_z = 1'h1; end // RULE_01
               OP_INV: begin res = ~f; upd_z = 1'h1; end // RULE_01
               OP_INC: begin res = f + 8'h01; upd_z = 1'h1; end // RULE_01
               OP_DEC: begin res = f - 8'h01; upd_z = 1'h1; end // RULE_01
               OP_MOV: begin res = f; upd_z = 1'h1; end // RULE_01
               OP_RL: begin
                  res  = {f[6:0], stat_r.c}; // RULE_04
                  st.c = f[7];
               end
               OP_RR: begin
                  res  = {stat_r.c, f[7:1]}; // RULE_04
                  st.c = f[0];
               end
               OP_SWAP: res = {f[3:0], f[7:4]}; // RULE_04
               OP_DECSKIP: begin
                  res  = f - 8'h01;
                  skip = (res == 8'h00); // RULE_05
               end
               OP_INCSKIP: begin
                  res  = f + 8'h01;
                  skip = (res == 8'h00); // RULE_05
               end
            endcase
         end
         GRP_BIT: begin
            unique case (ir_r[11:10])
               BIT_ZERO: begin res = f & ~(8'h01 << b); wr_f = 1'h1; end // RULE_07
               BIT_ONE: begin res = f | (8'h01 << b); wr_f = 1'h1; end // RULE_07
               BIT_TEST_ZERO: skip = ~f[b]; // RULE_08
               BIT_TEST_ONE: skip = f[b]; // RULE_08
            endcase
         end
         GRP_BRANCH: pcop = ir_r[11] ? PC_JUMP : PC_CALL; // RULE_12
         GRP_LIT: begin
            wr_a = 1'h1;
            unique casez (ir_r[11:8])
               4'b00??: res = k; // RULE_11
               4'b01??: begin res = k; pcop = PC_RETURN; end // RULE_11
               4'h8: begin res = k | w; upd_z = 1'h1; end // RULE_10
               4'h9: begin res = k & w; upd_z = 1'h1; end // RULE_10
               4'ha: begin res = k ^ w; upd_z = 1'h1; end // RULE_10
               4'hb: wr_a = 1'h0;
               4'b110?: begin {st.c, st.dc, res} = add_sub(k, w, 1'h1); upd_z = 1'h1; end // RULE_09
               4'b111?: begin {st.c, st.dc, res} = add_sub(k, w, 1'h0); upd_z = 1'h1; end // RULE_09
            endcase
         end
      endcase
      if (upd_z) begin
         st.z = (res == 8'h00);
      end
      if (skip) begin
         pcop = PC_SKIP; // RULE_18
      end

      phase_nxt   = phase_r;
      ir_nxt      = ir_r;
      flush_nxt   = flush_r;
      nop_nxt     = nop_r;
      addr_nxt    = addr_r;
      rd_nxt      = rd_r;
      rdata_nxt   = rdata_r;
      wdata_nxt   = wdata_r;
      acc_nxt     = acc_r;
      stat_nxt    = stat_r;
      target_nxt  = target_r;
      taken_nxt   = 1'h0;
      we_nxt      = 1'h0;
      presc_nxt   = 1'h0;
      kick_nxt    = 1'h0;
      standby_nxt = 1'h0;
      pcop_nxt    = PC_STEP;
      unique case (phase_r) // RULE_19
         PH_Q1: begin
            phase_nxt = PH_Q2;
            taken_nxt = 1'h1;
            flush_nxt = 1'h0;
            nop_nxt   = flush_r; // RULE_18
            ir_nxt    = flush_r ? NOP_WORD : INSTR_IN; // RULE_08
            addr_nxt  = INSTR_IN[6:0]; // RULE_21
            rd_nxt    = ~flush_r & names_file(INSTR_IN); // RULE_20
         end
         PH_Q2: begin
            phase_nxt = PH_Q3;
            rd_nxt    = 1'h0;
            rdata_nxt = (addr_r == PORT_ADDR) ? pin_s2_r : FILE_RDATA_IN; // RULE_16
         end
         PH_Q3: phase_nxt = PH_Q4;
         PH_Q4: begin
            phase_nxt   = PH_Q1;
            stat_nxt    = st;
            pcop_nxt    = pcop;
            flush_nxt   = (pcop != PC_STEP); // RULE_18
            kick_nxt    = kick;
            standby_nxt = stby;
            if (wr_f) begin
               we_nxt    = 1'h1;
               wdata_nxt = res;
               presc_nxt = (addr_r == TIMER_ZERO_ADDR) & PRESCALER_ON_TIMER_IN; // RULE_17
            end
            if (wr_a) begin
               acc_nxt = res;
            end
            if (pcop == PC_CALL || pcop == PC_JUMP) begin
               target_nxt = ir_r[10:0]; // RULE_12
            end
         end
      endcase
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         phase_r   <= PH_Q1;
         ir_r      <= NOP_WORD;
         flush_r   <= 1'h0;
         nop_r     <= 1'h0;
         taken_r   <= 1'h0;
         addr_r    <= 7'h00;
         rd_r      <= 1'h0;
         we_r      <= 1'h0;
         wdata_r   <= 8'h00;
         rdata_r   <= 8'h00;
         acc_r     <= ACC_RST;
         stat_r    <= STATUS_RST;
         pcop_r    <= PC_STEP;
         target_r  <= 11'h000;
         presc_r   <= 1'h0;
         kick_r    <= 1'h0;
         standby_r <= 1'h0;
         pin_s1_r  <= 8'h00;
         pin_s2_r  <= 8'h00;
      end else begin
         phase_r   <= phase_nxt;
         ir_r      <= ir_nxt;
         flush_r   <= flush_nxt;
         nop_r     <= nop_nxt;
         taken_r   <= taken_nxt;
         addr_r    <= addr_nxt;
         rd_r      <= rd_nxt;
         we_r      <= we_nxt;
         wdata_r   <= wdata_nxt;
         rdata_r   <= rdata_nxt;
         acc_r     <= acc_nxt;
         stat_r    <= stat_nxt;
         pcop_r    <= pcop_nxt;
         target_r  <= target_nxt;
         presc_r   <= presc_nxt;
         kick_r    <= kick_nxt;
         standby_r <= standby_nxt;
         pin_s1_r  <= PORT_PINS_IN;
         pin_s2_r  <= pin_s1_r;
      end
   end

   assign TAKEN_OUT         = taken_r;
   assign NOP_CYCLE_OUT     = nop_r;
   assign FILE_ADDR_OUT     = addr_r;
   assign FILE_RD_OUT       = rd_r;
   assign FILE_WE_OUT       = we_r;
   assign FILE_WDATA_OUT    = wdata_r;
   assign ACC_OUT           = acc_r;
   assign STATUS_OUT        = stat_r;
   assign PC_OP_OUT         = pcop_r;
   assign TARGET_OUT        = target_r;
   assign PRESCALER_CLR_OUT = presc_r;
   assign WDT_CLR_OUT       = kick_r;
   assign STANDBY_OUT       = standby_r;

   // Checks watch the registered outputs against the word held in ir_r.
   logic q4;
   logic sel_bit;
   assign q4      = (phase_r == PH_Q4) && !nop_r;
   assign sel_bit = rdata_r[ir_r[9:7]];

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);

   AST_FOUR_PHASES: assert property (TAKEN_OUT |=> !TAKEN_OUT [*3] ##1 TAKEN_OUT) // RULE_19
      else $error("instruction cycle is not four clocks");
   AST_READ_BEFORE_WRITE: assert property (FILE_WE_OUT |-> $past(FILE_RD_OUT, 3) // RULE_20
      && $past(FILE_ADDR_OUT, 3) == FILE_ADDR_OUT)
      else $error("file write without prior read of same address");
   AST_TWO_CYCLES: assert property (PC_OP_OUT != PC_STEP |=> NOP_CYCLE_OUT [*4] // RULE_18
      ##1 !NOP_CYCLE_OUT)
      else $error("flushed slot is not one no-op cycle");
   AST_NOP_QUIET: assert property (NOP_CYCLE_OUT |-> !FILE_RD_OUT && !FILE_WE_OUT) // RULE_08
      else $error("no-op cycle touched the file space");
   AST_DEST: assert property (q4 && ir_r[13:12] == GRP_BYTE && ir_r[11:9] != 3'h0 // RULE_03
      |=> FILE_WE_OUT == $past(ir_r[7]))
      else $error("destination bit not honoured");
   AST_CLEAR: assert property (q4 && ir_r[13:8] == {GRP_BYTE, OP_ZERO} // RULE_06
      |=> STATUS_OUT.z && (FILE_WE_OUT ? FILE_WDATA_OUT == 8'h00 : ACC_OUT == 8'h00))
      else $error("clear did not zero its target and set zero flag");
   AST_SWAP_FLAGS: assert property (q4 && ir_r[13:8] == {GRP_BYTE, OP_SWAP} // RULE_04
      |=> STATUS_OUT == $past(STATUS_OUT))
      else $error("nibble exchange changed status");
   AST_DEC_SKIP: assert property (q4 && ir_r[13:8] == {GRP_BYTE, OP_DECSKIP} // RULE_05
      |=> (PC_OP_OUT == PC_SKIP) == ($past(rdata_r) == 8'h01))
      else $error("decrement skip decision wrong");
   AST_BIT_TEST: assert property (q4 && ir_r[13:10] == {GRP_BIT, BIT_TEST_ZERO} // RULE_08
      |=> (PC_OP_OUT == PC_SKIP) == !$past(sel_bit))
      else $error("bit test skip decision wrong");
   AST_ADD_LIT: assert property (q4 && ir_r[13:9] == 5'h1f // RULE_09
      |=> ACC_OUT == 8'($past(acc_r) + $past(ir_r[7:0])))
      else $error("literal add result wrong");
   AST_KICK: assert property (WDT_CLR_OUT |-> STATUS_OUT.timeout_flag_n // RULE_14
      && STATUS_OUT.sleep_flag_n)
      else $error("watchdog kick did not set both flags");
   AST_PRESCALER: assert property (PRESCALER_CLR_OUT |-> FILE_WE_OUT // RULE_17
      && FILE_ADDR_OUT == TIMER_ZERO_ADDR)
      else $error("prescaler cleared without timer write");

   COV_SKIP: cover property (PC_OP_OUT == PC_SKIP ##5 TAKEN_OUT && !NOP_CYCLE_OUT);
   COV_CALL: cover property (PC_OP_OUT == PC_CALL);
   COV_STANDBY: cover property (STANDBY_OUT && !STATUS_OUT.sleep_flag_n);
   COV_TIMER: cover property (PRESCALER_CLR_OUT);

endmodule : mcu_14bit_instruction_decoder

// ===== dv/mcu_14bit_instruction_decoder_bench.sv
/*
 Self-checking bench for the 14-bit instruction decoder: a reference model predicts
 each word's result, a watcher compares it in the word's Q2 and next Q1 cycles.
 Assumes default parameters and a combinational file space held for the whole word.
*/
`timescale 1ns/100ps
module mcu_14bit_instruction_decoder_bench
   import mcu_decode_pkg::*;
   ;

   typedef struct packed {
      logic        rd;
      logic        chk_addr;
      logic [6:0]  addr;
      logic        we;
      logic [7:0]  wdata;
      logic [7:0]  acc;
      status_s     st;
      pc_op_e      pc;
      logic [10:0] tgt;
      logic        wdt;
      logic        sby;
      logic        pclr;
      logic        nop;
   } note_s;

   logic mclk, rst, presc_on, taken, nop_cycle, file_rd, file_we, presc_clr, wdt_clr, standby;
   logic [13:0] instr;
   logic [7:0]  rdata, pins, wdata, acc;
   logic [6:0]  file_addr;
   logic [10:0] target;
   status_s     status;
   pc_op_e      pc_op;
   note_s       notes[$];
   logic [7:0]  acc_m;
   status_s     st_m;
   logic [10:0] tgt_m;
   logic        flush_m, watch_done;
   int          n_mismatch, comparisons, cyc;
   logic [7:0]  ctl[8] = '{8'h08, 8'h09, 8'h64, 8'h63, 8'h00, 8'h60, 8'h20, 8'h0a};

   mcu_14bit_instruction_decoder dut_u (
      .MCLK_IN(mclk), .RST_IN(rst), .INSTR_IN(instr), .FILE_RDATA_IN(rdata),
      .PORT_PINS_IN(pins), .PRESCALER_ON_TIMER_IN(presc_on), .TAKEN_OUT(taken),
      .NOP_CYCLE_OUT(nop_cycle), .FILE_ADDR_OUT(file_addr), .FILE_RD_OUT(file_rd),
      .FILE_WE_OUT(file_we), .FILE_WDATA_OUT(wdata), .ACC_OUT(acc), .STATUS_OUT(status),
      .PC_OP_OUT(pc_op), .TARGET_OUT(target), .PRESCALER_CLR_OUT(presc_clr),
      .WDT_CLR_OUT(wdt_clr), .STANDBY_OUT(standby));

   always #50 mclk = ~mclk;

   task automatic complete_run();
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_flag

   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_status(input status_s got, input status_s exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_status

   task automatic chk_pc(input pc_op_e got, input pc_op_e exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_pc

   // Adds or subtracts (a minus b) and sets carry, digit carry and zero.
   function automatic logic [7:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic sub);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] bb;
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
      st_m.c = s[8];
      st_m.dc = h[4];
      st_m.z = (s[7:0] == 8'h00);
      return s[7:0];
   endfunction : arith

   task automatic model(input logic [13:0] w, input logic [7:0] d, input logic pr,
                        output note_s n);
      logic [7:0] src, r;
      logic       wr, skip;
      src = (w[6:0] == PORT_ADDR_DFLT) ? pins : d;
      n = '0;
      n.pc = PC_STEP;
      n.addr = w[6:0];
      r = 8'h00;
      wr = 1'b0;
      skip = 1'b0;
      if (flush_m) begin
         n.nop = 1'b1;
      end else if (w[13:12] == GRP_BYTE && w[13:7] == 7'h00) begin
         case (w[7:0])
            CTL_RETURN: n.pc = PC_RETURN;
            CTL_RETI: n.pc = PC_RETI;
            CTL_KICK: begin
               st_m.timeout_flag_n = 1'b1;
               st_m.sleep_flag_n = 1'b1;
               n.wdt = 1'b1;
            end
            CTL_SLEEP: begin
               st_m.timeout_flag_n = 1'b1;
               st_m.sleep_flag_n = 1'b0;
               n.sby = 1'b1;
            end
            default: ;
         endcase
      end else if (w[13:12] == GRP_BYTE) begin
         n.rd = !(w[11:8] == OP_ZERO && !w[7]);
         n.chk_addr = n.rd;
         wr = w[7];
         case (w[11:8])
            OP_STORE: r = acc_m;
            OP_ZERO: r = 8'h00;
            OP_SUB: r = arith(src, acc_m, 1'b1);
            OP_DEC: r = src - 8'h01;
            OP_OR: r = src | acc_m;
            OP_AND: r = src & acc_m;
            OP_XOR: r = src ^ acc_m;
            OP_ADD: r = arith(src, acc_m, 1'b0);
            OP_MOV: r = src;
            OP_INV: r = ~src;
            OP_INC: r = src + 8'h01;
            OP_RR: {r, st_m.c} = {st_m.c, src};
            OP_RL: {st_m.c, r} = {src, st_m.c};
            OP_SWAP: r = {src[3:0], src[7:4]};
            OP_DECSKIP: r = src - 8'h01;
            default: r = src + 8'h01;
         endcase
         if (w[11:8] inside {OP_DECSKIP, OP_INCSKIP})
            skip = (r == 8'h00);
         if (w[11:8] inside {OP_ZERO, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_MOV, OP_INV, OP_INC})
            st_m.z = (r == 8'h00);
         if (!wr)
            acc_m = r;
      end else if (w[13:12] == GRP_BIT) begin
         n.rd = 1'b1;
         n.chk_addr = 1'b1;
         r = src;
         r[w[9:7]] = w[10];
         wr = !w[11];
         skip = w[11] && (src[w[9:7]] == w[10]);
      end else if (w[13:12] == GRP_BRANCH) begin
         n.pc = w[11] ? PC_JUMP : PC_CALL;
         tgt_m = w[10:0];
      end else begin
         casez (w[11:8])
            4'b00??: acc_m = w[7:0];
            4'b01??: begin
               acc_m = w[7:0];
               n.pc = PC_RETURN;
            end
            4'b1000: acc_m = acc_m | w[7:0];
            4'b1001: acc_m = acc_m & w[7:0];
            4'b1010: acc_m = acc_m ^ w[7:0];
            4'b110?: acc_m = arith(w[7:0], acc_m, 1'b1);
            4'b111?: acc_m = arith(w[7:0], acc_m, 1'b0);
            default: ;
         endcase
         if (w[11:8] inside {4'h8, 4'h9, 4'ha})
            st_m.z = (acc_m == 8'h00);
      end
      if (skip)
         n.pc = PC_SKIP;
      n.we = wr;
      n.wdata = r;
      n.pclr = wr && pr && w[6:0] == TIMER_ZERO_ADDR_DFLT;
      flush_m = !flush_m && n.pc != PC_STEP;
      n.acc = acc_m;
      n.st = st_m;
      n.tgt = tgt_m;
   endtask : model

   task automatic issue(input logic [13:0] w, input logic [7:0] d, input logic pr);
      note_s n;
      instr <= w;
      rdata <= d;
      presc_on <= pr;
      model(w, d, pr, n);
      notes.push_back(n);
      repeat (4) @(posedge mclk);
   endtask : issue

   function automatic logic [7:0] pick();
      case ($urandom_range(3))
         0: return 8'h00;
         1: return 8'h01;
         2: return 8'hff;
         default: return 8'($urandom);
      endcase
   endfunction : pick

   initial begin : watch
      note_s n;
      @(negedge rst);
      repeat (2) @(negedge mclk);
      while (notes.size() > 0) begin
         n = notes.pop_front();
         chk_flag(file_rd, n.rd);
         if (!n.nop) chk_flag(taken, 1'b1);
         repeat (3) @(negedge mclk);
         chk_flag(taken, 1'b0);
         chk_flag(nop_cycle, n.nop);
         chk_flag(file_we, n.we);
         if (n.we) chk_data(wdata, n.wdata);
         if (n.chk_addr) chk_data(file_addr, n.addr);
         chk_data(acc, n.acc);
         chk_status(status, n.st);
         chk_pc(pc_op, n.pc);
         chk_data(target, n.tgt);
         chk_flag(wdt_clr, n.wdt);
         chk_flag(standby, n.sby);
         chk_flag(presc_clr, n.pclr);
         @(negedge mclk);
      end
      watch_done = 1'b1;
   end

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      instr = NOP_WORD;
      rdata = 8'h00;
      pins = 8'h00;
      presc_on = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      cyc = 0;
      watch_done = 1'b0;
      acc_m = ACC_RST;
      st_m = STATUS_RST;
      tgt_m = 11'h000;
      flush_m = 1'b0;
      void'($urandom(24436));
      @(posedge mclk);
      pins <= 8'($urandom);
      repeat (19) @(posedge mclk);
      @(negedge mclk);
      chk_data(acc, ACC_RST);
      chk_status(status, STATUS_RST);
      chk_pc(pc_op, PC_STEP);
      @(posedge mclk);
      rst <= 1'b0;
      issue({2'b00, OP_DECSKIP, 1'b0, 7'h10}, 8'h01, 1'b0);
      issue({2'b10, 1'b1, 11'h7ff}, 8'h00, 1'b0);
      issue({2'b00, OP_INCSKIP, 1'b1, 7'h11}, 8'hff, 1'b0);
      issue(NOP_WORD, 8'h00, 1'b0);
      issue({2'b00, OP_INC, 1'b1, PORT_ADDR_DFLT}, ~pins, 1'b0);
      issue({2'b00, OP_STORE, 1'b1, TIMER_ZERO_ADDR_DFLT}, 8'h00, 1'b1);
      issue({2'b00, OP_ZERO, 1'b1, 7'h7f}, 8'h5a, 1'b0);
      for (int i = 0; i < 32; i++)
         issue({2'b00, 4'(i), 1'(i >> 4), 4'h0, 3'($urandom)}, pick(), 1'b1);
      for (int i = 0; i < 16; i++)
         issue({2'b01, 2'(i), 3'($urandom), 4'h0, 3'($urandom)}, pick(), 1'b0);
      for (int i = 0; i < 4; i++)
         issue({2'b10, 1'(i), 11'($urandom)}, 8'h00, 1'b0);
      for (int i = 0; i < 16; i++)
         issue({2'b11, 4'(i), 8'($urandom)}, 8'h00, 1'b0);
      foreach (ctl[i])
         issue({6'h00, ctl[i]}, 8'h00, 1'b0);
      repeat (200)
         issue(14'($urandom), pick(), 1'($urandom));
      while (!watch_done)
         @(posedge mclk);
      complete_run();
   end
endmodule : mcu_14bit_instruction_decoder_bench
